// *** src/pcf_consts.svh ***
// Constants of the instruction sequencing core: offsets, fields, resets, timing
`ifndef PCF_CONSTS_SVH
`define PCF_CONSTS_SVH
`define PC_W 15
`define DATA_W 8
`define REG_ADDR_W 8
`define HOLD_W 7
`define CNT_W 8
`define PHASE_COUNT 4
`define OFS_COUNTER_LOW 8'h00
`define OFS_EXEC_LOW 8'h04
`define OFS_EXEC_HIGH 8'h08
`define OFS_CORE_STATUS 8'h0C
`define RESET_VECTOR 15'h0000
`define CODE_WORDS_DEF 32768
`define BANK_THRESHOLD 8192
`define PHASE_DIV_DEF 1
`define PHASE_T1 4'h1
`define PHASE_T2 4'h2
`define PHASE_T3 4'h4
`define PHASE_T4 4'h8
`define PAGE_BITS 8
`define UPPER_LO 8
`define UPPER_HI 12
`define BANK_LO 13
`define BANK_HI 14
`define ST_EXEC_VALID 0
`define ST_FETCH_VALID 1
`define ST_EXT_BUSY 2
`define ST_PCL_PEND 3
`endif

// *** src/pcf_pkg.sv ***
// Types shared by the instruction sequencing core
`include "pcf_consts.svh"
package pcf_pkg;
    typedef enum logic [2:0] {
        KIND_SEQ    = 3'b000,
        KIND_EXT    = 3'b001,
        KIND_JUMP   = 3'b010,
        KIND_VECTOR = 3'b011,
        KIND_SKIP   = 3'b100
    } ex_kind_e;

    typedef logic [`PC_W-1:0] addr_t;

    typedef struct packed {
        logic [`CNT_W-1:0] cnt;
        logic [`PHASE_COUNT-1:0] phase;
    } phase_state_s;

    typedef struct packed {
        addr_t pc;
        addr_t fetch_addr;
        logic fetch_valid;
        addr_t exec_addr;
        logic exec_valid;
        logic ext_busy;
        logic ext_tail;
        logic pcl_pend;
        logic [`DATA_W-1:0] pcl_data;
        logic [`HOLD_W-1:0] hold;
        logic [`DATA_W-1:0] rdata;
    } core_state_s;
endpackage : pcf_pkg

// *** src/phase_gen.sv ***
// Four-phase generator: one-hot phase ring advanced by a divider enable
`timescale 1ns/1ps
`default_nettype none
`include "pcf_consts.svh"
module phase_gen
    import pcf_pkg::*;
#(
    parameter int DIV = `PHASE_DIV_DEF
) (
    input wire logic ref_clk,
    input wire logic rstn,
    output logic [`PHASE_COUNT-1:0] phase_out,
    output logic phase_first,
    output logic phase_last
);
    if (DIV < 1 || DIV > 255) begin : g_bad_div
        $error("phase_gen: DIV must be 1 to 255");
    end

    phase_state_s s;
    phase_state_s n;

    assign phase_out = s.phase;
    assign phase_first = (s.cnt == '0);
    assign phase_last = (s.cnt == `CNT_W'(DIV - 1));

    always_comb begin
        n = s;
        if (phase_last) begin
            n.cnt = '0;
            n.phase = {s.phase[`PHASE_COUNT-2:0], s.phase[`PHASE_COUNT-1]};
        end else begin
            n.cnt = s.cnt + `CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '{cnt: '0, phase: `PHASE_T1};
        end else begin
            s <= n;
        end
    end
endmodule : phase_gen
`default_nettype wire

// *** src/pc_fetch_core.sv ***
// Program counter, fetch/execute overlap and execution address readback
//
// Summary of operation
// - Four non-overlapping phases make one instruction cycle
// - Counter advances and fetch starts at T1
// - Decode and execute occupy phases T2 to T4
// - Fetch overlaps execute; extended ops take two
// - Counter-changing instructions cost one extra cycle
// - Jump obtains target, flushes prefetch, then fetches
// - Counter increments unless transfer is nonconsecutive
// - Two-bit bank pointer tops counter above 8K
// - Only low byte writable; upper bits protected
// - Jump, call, interrupt, reset load full address
// - Taken skip discards prefetch, inserts dummy cycle
// - Low byte write makes in-page jump
// - Low byte write inserts one dummy cycle
// - Low readback returns address, captures high part
// - High readback returns captured buffer, not live
// - Low readback is eight bits, resets zero
// - High readback seven bits, bit seven zero
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pcf_consts.svh"
module pc_fetch_core
    import pcf_pkg::*;
#(
    parameter int CODE_WORDS = `CODE_WORDS_DEF,
    parameter int PHASE_DIV = `PHASE_DIV_DEF
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [`REG_ADDR_W-1:0] reg_addr,
    input wire logic [`DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`DATA_W-1:0] reg_rdata,
    output logic [`PHASE_COUNT-1:0] cycle_phases,
    output logic fetch_req,
    output logic [`PC_W-1:0] fetch_addr,
    output logic exec_valid,
    output logic [`PC_W-1:0] exec_addr,
    input wire ex_kind_e ex_kind,
    input wire logic [`PC_W-1:0] ex_target,
    output logic [1:0] code_bank_pointer,
    output logic [4:0] counter_upper_bits
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (CODE_WORDS < 256 || CODE_WORDS > 32768 || (CODE_WORDS & (CODE_WORDS - 1)) != 0) begin : g_bad_words
        $error("pc_fetch_core: CODE_WORDS must be a power of two, 256 to 32768");
    end

    localparam addr_t ADDR_MASK = addr_t'(CODE_WORDS - 1);
    localparam bit HAS_BANK = (CODE_WORDS > `BANK_THRESHOLD);
    localparam core_state_s RESET_STATE = '{pc: `RESET_VECTOR, default: '0};

    function automatic addr_t wrap_addr(input addr_t a);
        wrap_addr = a & ADDR_MASK;
    endfunction : wrap_addr

    // ------------------------------------------------------------
    // Phase generation
    // ------------------------------------------------------------
    logic phase_first;
    logic phase_last;
    logic t1_go;
    logic t4_end;

    phase_gen #(
        .DIV(PHASE_DIV)
    ) u_phase (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .phase_out(cycle_phases),
        .phase_first(phase_first),
        .phase_last(phase_last)
    );

    assign t1_go = (cycle_phases == `PHASE_T1) && phase_first;
    assign t4_end = (cycle_phases == `PHASE_T4) && phase_last;

    // ------------------------------------------------------------
    // State and decode of the executing slot
    // ------------------------------------------------------------
    core_state_s s;
    core_state_s n;
    logic slot_live;
    logic jump_go;
    logic skip_go;
    logic ext_go;
    logic wr_pcl;
    logic rd_low;
    logic rd_high;

    // Flushed slots and the tail of an extended op carry no outcome
    assign slot_live = t4_end && s.exec_valid && !s.ext_tail;
    assign jump_go = slot_live && (ex_kind == KIND_JUMP || ex_kind == KIND_VECTOR);
    assign skip_go = slot_live && (ex_kind == KIND_SKIP);
    assign ext_go = slot_live && (ex_kind == KIND_EXT);
    assign wr_pcl = reg_wr && (reg_addr == `OFS_COUNTER_LOW);
    assign rd_low = reg_rd && (reg_addr == `OFS_EXEC_LOW);
    assign rd_high = reg_rd && (reg_addr == `OFS_EXEC_HIGH);

    assign fetch_req = t1_go && !s.ext_busy;
    assign fetch_addr = s.fetch_addr;
    assign exec_valid = s.exec_valid;
    assign exec_addr = s.exec_addr;
    assign reg_rdata = s.rdata;
    assign counter_upper_bits = s.pc[`UPPER_HI:`UPPER_LO];
    assign code_bank_pointer = HAS_BANK ? s.pc[`BANK_HI:`BANK_LO] : 2'h0;

    always_comb begin
        n = s;
        n.rdata = '0;

        // --------------------------------------------------------
        // Instruction cycle boundary
        // --------------------------------------------------------
        if (t1_go) begin
            if (s.ext_busy) begin
                // Second cycle of an extended op: pipeline holds
                n.ext_busy = 1'b0;
                n.ext_tail = 1'b1;
            end else begin
                n.ext_tail = 1'b0;
                n.exec_addr = s.fetch_addr;
                n.exec_valid = s.fetch_valid;
                n.fetch_addr = s.pc;
                n.fetch_valid = 1'b1;
                n.pc = wrap_addr(s.pc + addr_t'(1));
            end
        end

        // --------------------------------------------------------
        // Outcome of the executing instruction at end of T4
        // --------------------------------------------------------
        if (ext_go) begin
            n.ext_busy = 1'b1;
        end
        if (jump_go) begin
            // Target taken now; the stale prefetch becomes a dummy slot
            n.pc = wrap_addr(ex_target);
            n.fetch_valid = 1'b0;
        end
        if (skip_go) begin
            n.fetch_valid = 1'b0;
        end
        if (t4_end && s.pcl_pend) begin
            // Only the low byte moves, so the jump stays in its page
            n.pc[`PAGE_BITS-1:0] = s.pcl_data;
            n.fetch_valid = 1'b0;
            n.pcl_pend = 1'b0;
        end

        // --------------------------------------------------------
        // Register port
        // --------------------------------------------------------
        // A write landing in the apply cycle is kept, not lost
        if (wr_pcl) begin
            n.pcl_pend = 1'b1;
            n.pcl_data = reg_wdata;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `OFS_COUNTER_LOW: begin
                    n.rdata = s.pc[`PAGE_BITS-1:0];
                end
                `OFS_EXEC_LOW: begin
                    n.rdata = s.exec_addr[`PAGE_BITS-1:0];
                    n.hold = s.exec_addr[`PC_W-1:`PAGE_BITS];
                end
                `OFS_EXEC_HIGH: begin
                    n.rdata = {1'b0, s.hold};
                end
                `OFS_CORE_STATUS: begin
                    n.rdata[`ST_EXEC_VALID] = s.exec_valid;
                    n.rdata[`ST_FETCH_VALID] = s.fetch_valid;
                    n.rdata[`ST_EXT_BUSY] = s.ext_busy || s.ext_tail;
                    n.rdata[`ST_PCL_PEND] = s.pcl_pend;
                end
                default: begin
                    n.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s <= RESET_STATE;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence seq_jump_taken;
        jump_go && !s.pcl_pend;
    endsequence

    sequence seq_flush_then_fetch;
        t1_go && !s.fetch_valid && !s.ext_busy;
    endsequence

    sequence seq_pcl_apply;
        t4_end && s.pcl_pend && !jump_go;
    endsequence

    // A discarded prefetch shows up as exactly one dummy issue
    sequence seq_dummy_issue;
        t1_go ##1 !exec_valid && s.fetch_valid;
    endsequence

    chk_phase_onehot: assert property (
        $onehot(cycle_phases)
    ) else $error("phase ring is not one-hot");

    chk_phase_ring: assert property (
        phase_last && cycle_phases == `PHASE_T4 |=> cycle_phases == `PHASE_T1 && phase_first
    ) else $error("T4 not followed by T1");

    chk_fetch_in_t1: assert property (
        fetch_req |-> cycle_phases == `PHASE_T1 ##1 fetch_addr == $past(s.pc)
    ) else $error("fetch outside T1 or wrong address");

    chk_pc_quiet: assert property (
        !t1_go && !t4_end |=> $stable(s.pc)
    ) else $error("counter moved outside T1 or T4 end");

    chk_pc_step: assert property (
        t1_go && !s.ext_busy |=> s.pc == wrap_addr($past(s.pc) + addr_t'(1))
    ) else $error("counter did not step by one");

    chk_ext_hold: assert property (
        t1_go && s.ext_busy |=> $stable(exec_addr) && $stable(fetch_addr) && s.ext_tail
    ) else $error("extended op did not hold the pipeline");

    chk_ext_start: assert property (
        ext_go |=> s.ext_busy
    ) else $error("extended op did not claim a second cycle");

    chk_jump_load: assert property (
        seq_jump_taken |=> s.pc == wrap_addr($past(ex_target)) && !s.fetch_valid
    ) else $error("jump target not loaded or prefetch kept");

    chk_flush_slot: assert property (
        seq_flush_then_fetch |=> !exec_valid && s.fetch_valid
    ) else $error("flushed prefetch reached execution");

    chk_skip_dummy: assert property (
        skip_go && !s.pcl_pend |=> !s.fetch_valid && $stable(s.pc)
    ) else $error("taken skip kept the prefetch");

    chk_pcl_write: assert property (
        seq_pcl_apply |=> s.pc[`PAGE_BITS-1:0] == $past(s.pcl_data) && !s.fetch_valid
    ) else $error("low byte write not applied as in-page jump");

    chk_pcl_upper: assert property (
        seq_pcl_apply |=> s.pc[`PC_W-1:`PAGE_BITS] == $past(s.pc[`PC_W-1:`PAGE_BITS])
    ) else $error("low byte write disturbed upper bits");

    chk_low_read: assert property (
        rd_low |=> reg_rdata == $past(exec_addr[`PAGE_BITS-1:0]) && s.hold == $past(exec_addr[`PC_W-1:`PAGE_BITS])
    ) else $error("low readback or capture wrong");

    chk_high_read: assert property (
        rd_high |=> reg_rdata == {1'b0, $past(s.hold)}
    ) else $error("high readback not from holding buffer");

    chk_high_bit7: assert property (
        rd_high |=> !reg_rdata[`DATA_W-1]
    ) else $error("high readback bit seven not zero");

    chk_hold_stable: assert property (
        !rd_low |=> $stable(s.hold)
    ) else $error("holding buffer changed without low read");

    chk_dead_slot: assert property (
        t4_end && !s.exec_valid && !s.pcl_pend |=> $stable(s.pc) && !s.ext_busy
    ) else $error("dummy slot changed core state");

    chk_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == '0
    ) else $error("read data outside its cycle");

    // ------------------------------------------------------------
    // Pipeline chains and register port
    // ------------------------------------------------------------
    chk_jump_chain: assert property (
        seq_jump_taken |=> seq_dummy_issue
    ) else $error("jump not followed by one dummy issue");

    chk_skip_chain: assert property (
        skip_go |=> seq_dummy_issue
    ) else $error("taken skip not followed by one dummy issue");

    chk_pcl_chain: assert property (
        seq_pcl_apply ##0 !ext_go |=> seq_dummy_issue
    ) else $error("low byte write not followed by one dummy issue");

    chk_vector_load: assert property (
        jump_go && ex_kind == KIND_VECTOR && !s.pcl_pend |=> s.pc == wrap_addr($past(ex_target))
    ) else $error("vector did not load full address");

    chk_exec_advance: assert property (
        t1_go && !s.ext_busy |=> exec_addr == $past(fetch_addr) && exec_valid == $past(s.fetch_valid)
    ) else $error("prefetched slot did not move to execution");

    chk_tail_clear: assert property (
        t1_go && !s.ext_busy |=> !s.ext_tail
    ) else $error("extended tail outlived its cycle");

    chk_tail_mute: assert property (
        t4_end && s.ext_tail && !s.pcl_pend |=> $stable(s.pc) && !s.ext_busy && $stable(s.fetch_valid)
    ) else $error("extended tail acted on an outcome");

    chk_wr_pending: assert property (
        wr_pcl |=> s.pcl_pend && s.pcl_data == $past(reg_wdata)
    ) else $error("low byte write not held pending");

    chk_ro_write: assert property (
        reg_wr && !wr_pcl && !t4_end |=> $stable(s.pcl_pend) && $stable(s.pcl_data)
    ) else $error("write to read-only address took effect");

    chk_live_low: assert property (
        reg_rd && reg_addr == `OFS_COUNTER_LOW |=> reg_rdata == $past(s.pc[`PAGE_BITS-1:0])
    ) else $error("counter low byte readback wrong");

    chk_status_read: assert property (
        reg_rd && reg_addr == `OFS_CORE_STATUS |=> reg_rdata == {4'h0, $past(s.pcl_pend),
            ($past(s.ext_busy) || $past(s.ext_tail)), $past(s.fetch_valid), $past(s.exec_valid)}
    ) else $error("status readback wrong");

    chk_unmapped_zero: assert property (
        reg_rd && !rd_low && !rd_high && reg_addr != `OFS_COUNTER_LOW && reg_addr != `OFS_CORE_STATUS
            |=> reg_rdata == '0
    ) else $error("unmapped read returned data");
endmodule : pc_fetch_core
`default_nettype wire

// *** verif/program_counter_fetch_pipeline_bench.sv ***
// Self-checking bench for the program counter and fetch pipeline core
`timescale 1ns/1ps
`default_nettype none
`include "pcf_consts.svh"
module program_counter_fetch_pipeline_bench
    import pcf_pkg::*;
;
// ----------------------------------------
// Stimulus and design
// ----------------------------------------
logic ref_clk = 1'b0;
logic rstn = 1'b0;
logic [7:0] reg_addr = 8'h00;
logic [7:0] reg_wdata = 8'h00;
logic reg_wr = 1'b0;
logic reg_rd = 1'b0;
ex_kind_e ex_kind = KIND_SEQ;
addr_t ex_target = 15'h0000;
logic [7:0] reg_rdata;
logic [3:0] cycle_phases;
logic fetch_req;
logic [14:0] fetch_addr;
logic exec_valid;
logic [14:0] exec_addr;
logic [1:0] code_bank_pointer;
logic [4:0] counter_upper_bits;
int fails = 0;
int samples_checked = 0;
addr_t pc_exp;

always #20 ref_clk = ~ref_clk;

pc_fetch_core #(.CODE_WORDS(32768), .PHASE_DIV(1)) i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cycle_phases(cycle_phases),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .exec_valid(exec_valid),
    .exec_addr(exec_addr), .ex_kind(ex_kind), .ex_target(ex_target),
    .code_bank_pointer(code_bank_pointer), .counter_upper_bits(counter_upper_bits)
);
// ----------------------------------------
// Shared tasks
// ----------------------------------------
task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
endtask : summarize

task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv) begin
        fails++;
        $display("unexpected %s: expected %0h seen %0h", what, expv, seen);
    end
endtask : check

// Bounded wait; a hung phase ring ends the run
task automatic to_phase(input logic [3:0] ph);
    int n;
    n = 0;
    do begin
        @(negedge ref_clk);
        n++;
    end while (cycle_phases !== ph && n < 40);
    if (cycle_phases !== ph) begin
        fails++;
        summarize();
    end
endtask : to_phase

task automatic rd(input logic [7:0] a, input logic [7:0] expv, input string what);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    check(what, reg_rdata, expv);
endtask : rd

task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
endtask : wr

// Outcome stands during T4 of a real slot only
task automatic outcome(input ex_kind_e k, input addr_t tgt);
    int n;
    n = 0;
    do begin
        to_phase(`PHASE_T3);
        n++;
    end while (exec_valid !== 1'b1 && n < 8);
    if (exec_valid !== 1'b1) begin
        fails++;
        summarize();
    end
    @(posedge ref_clk);
    ex_kind <= k;
    ex_target <= tgt;
    @(posedge ref_clk);
    ex_kind <= KIND_SEQ;
endtask : outcome
// ----------------------------------------
// Scenarios
// ----------------------------------------
task automatic t_reset();
    check("reset phase", cycle_phases, `PHASE_T1);
    check("reset valid", exec_valid, 1'h0);
    check("reset fetch", fetch_addr, `RESET_VECTOR);
    check("reset rdata", reg_rdata, 8'h00);
    @(posedge ref_clk);
    @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`OFS_EXEC_LOW, 8'h00, "low after reset");
    rd(`OFS_EXEC_HIGH, 8'h00, "high after reset");
    rd(`OFS_CORE_STATUS, 8'h03, "status after reset");
    $display("reset test done");
endtask : t_reset

task automatic t_jump(input ex_kind_e k, input addr_t x);
    addr_t nx;
    nx = x + 15'h0002;
    outcome(k, x);
    to_phase(`PHASE_T2);
    check("jump fetch", fetch_addr, x);
    check("flushed slot", exec_valid, 1'h0);
    to_phase(`PHASE_T2);
    check("jump exec", exec_addr, x);
    check("jump valid", exec_valid, 1'h1);
    check("bank pointer", code_bank_pointer, nx[14:13]);
    check("upper bits", counter_upper_bits, nx[12:8]);
    pc_exp = x + 15'h0001;
    check("after jump fetch", fetch_addr, pc_exp);
    $display("jump test done %0h", x);
endtask : t_jump

task automatic t_seq();
    logic [3:0] ph;
    ph = `PHASE_T2;
    repeat (12) begin
        @(negedge ref_clk);
        ph = {ph[2:0], ph[3]};
        check("phase", cycle_phases, ph);
        check("fetch strobe", fetch_req, ph == `PHASE_T1);
        if (ph == `PHASE_T2) begin
            pc_exp = pc_exp + 15'h0001;
            check("seq fetch", fetch_addr, pc_exp);
            check("seq exec", exec_addr, pc_exp - 15'h0001);
            check("seq valid", exec_valid, 1'h1);
        end
    end
    $display("sequential test done");
endtask : t_seq

task automatic t_readback();
    // Read-only target: this write must leave no trace
    wr(`OFS_EXEC_LOW, 8'h5A);
    to_phase(`PHASE_T2);
    rd(`OFS_EXEC_LOW, 8'hFF, "exec low");
    rd(`OFS_EXEC_HIGH, 8'h7E, "exec high");
    rd(8'h10, 8'h00, "unmapped");
    $display("readback test done");
endtask : t_readback

task automatic t_skip();
    outcome(KIND_SKIP, 15'h0000);
    to_phase(`PHASE_T2);
    check("skip fetch", fetch_addr, pc_exp + 15'h0001);
    check("skip dummy", exec_valid, 1'h0);
    to_phase(`PHASE_T2);
    check("skip exec", exec_addr, pc_exp + 15'h0001);
    check("skip valid", exec_valid, 1'h1);
    pc_exp = pc_exp + 15'h0002;
    check("skip next", fetch_addr, pc_exp);
    $display("skip test done");
endtask : t_skip

// A jump offered in the held second cycle must be dropped
task automatic t_ext();
    outcome(KIND_EXT, 15'h0000);
    to_phase(`PHASE_T1);
    check("ext no fetch", fetch_req, 1'h0);
    to_phase(`PHASE_T3);
    check("ext frozen", fetch_addr, pc_exp);
    @(posedge ref_clk);
    ex_kind <= KIND_JUMP;
    @(posedge ref_clk);
    ex_kind <= KIND_SEQ;
    to_phase(`PHASE_T2);
    pc_exp = pc_exp + 15'h0001;
    check("ext resume", fetch_addr, pc_exp);
    check("ext exec", exec_addr, pc_exp - 15'h0001);
    $display("extended test done");
endtask : t_ext

task automatic t_pcl();
    addr_t nx;
    nx = pc_exp + 15'h0001;
    nx[7:0] = 8'h77;
    wr(`OFS_COUNTER_LOW, 8'h77);
    to_phase(`PHASE_T2);
    check("page jump", fetch_addr, nx);
    check("pcl dummy", exec_valid, 1'h0);
    to_phase(`PHASE_T2);
    check("pcl exec", exec_addr, nx);
    check("pcl valid", exec_valid, 1'h1);
    rd(`OFS_COUNTER_LOW, 8'h79, "live low byte");
    $display("low byte write test done");
endtask : t_pcl
// ----------------------------------------
// Main sequence
// ----------------------------------------
initial begin
    @(negedge ref_clk);
    t_reset();
    t_jump(KIND_VECTOR, 15'h0123);
    t_seq();
    t_jump(KIND_VECTOR, 15'h7EFE);
    t_readback();
    t_jump(KIND_JUMP, 15'h1FF0);
    rd(`OFS_EXEC_HIGH, 8'h7E, "held high");
    t_jump(KIND_JUMP, 15'h5A34);
    t_skip();
    t_ext();
    t_pcl();
    summarize();
end
endmodule : program_counter_fetch_pipeline_bench
`default_nettype wire
